// ---- bench/crf_eu_model.sv ----
// Execution unit and interrupt acknowledge model
`timescale 1ns/1ps
module crf_eu_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_eu_rdata,
  output logic             o_we,
  output logic [3:0]       o_wsel,
  output logic [1:0]       o_wmode,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_rsel,
  output logic [1:0]       o_rmode,
  output logic [3:0]       o_alu,
  output logic             o_upd,
  output logic             o_pcl,
  output logic [23:0]      o_pc,
  output logic             o_ack,
  output logic             o_swi,
  output logic [5:0]       o_swi_num
);
  initial begin
    {o_we, o_wsel, o_wmode, o_wdata, o_rsel, o_rmode} = '0;
    {o_alu, o_upd, o_pcl, o_pc, o_ack, o_swi, o_swi_num} = '0;
  end
  // One register write; data inverted once released
  task automatic wr(input logic [3:0] s, input logic [1:0] m,
                    input logic [31:0] d);
    @(posedge i_clk);
    o_we <= 1'b1;
    o_wsel <= s;
    o_wmode <= m;
    o_wdata <= d;
    @(posedge i_clk);
    o_we <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] s, input logic [1:0] m,
                    output logic [31:0] v);
    @(posedge i_clk);
    o_rsel <= s;
    o_rmode <= m;
    repeat (2) @(posedge i_clk);
    v = i_eu_rdata;
  endtask
  // Strobes: 0 alu flags, 1 hw ack, 2 software interrupt, 3 pc load
  task automatic ev(input int k, input logic [23:0] d);
    @(posedge i_clk);
    case (k)
      0: begin
        o_upd <= 1'b1;
        o_alu <= d[3:0];
      end
      1: o_ack <= 1'b1;
      2: begin
        o_swi <= 1'b1;
        o_swi_num <= d[5:0];
      end
      default: begin
        o_pcl <= 1'b1;
        o_pc <= d;
      end
    endcase
    @(posedge i_clk);
    {o_upd, o_ack, o_swi, o_pcl} <= '0;
  endtask
endmodule

// ---- bench/crf_top_tb.sv ----
// Self-checking bench of the CPU register file
`timescale 1ns/1ps
module crf_top_tb;
  logic        i_clk;
  logic        i_nrst;
  logic        ce;
  logic        psel, pen, pwr, irq, o_pready, o_pslverr, o_irq_accept;
  logic        we, upd, pcl, ack, swi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, o_prdata, o_eu_rdata, wdata, v;
  logic [3:0]  wsel, rsel, alu;
  logic [1:0]  wmode, rmode;
  logic [2:0]  lvl;
  logic [5:0]  swn;
  logic [23:0] pcn, o_a0, o_a1, o_sb, o_fb, o_sp, o_vector_table_base, o_pc;
  logic [15:0] o_flags;
  logic [32:0] e_n;
  logic [32:0] q[$];
  logic [31:0] bv[16];
  logic [31:0] rs = 32'h194b8e42;
  int          n_mismatch = 0;
  int          checks = 0;

  crf_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_eu_we(we), .i_eu_wsel(wsel),
    .i_eu_wmode(wmode), .i_eu_wdata(wdata), .i_eu_rsel(rsel),
    .i_eu_rmode(rmode), .o_eu_rdata(o_eu_rdata), .i_alu_upd(upd),
    .i_alu_c(alu[0]), .i_alu_z(alu[1]), .i_alu_s(alu[2]),
    .i_alu_o(alu[3]), .i_pc_load(pcl), .i_pc_next(pcn),
    .i_irq_req(irq), .i_irq_lvl(lvl), .o_irq_accept(o_irq_accept),
    .i_ack_hw(ack), .i_swi(swi), .i_swi_num(swn), .o_a0(o_a0),
    .o_a1(o_a1), .o_sb(o_sb), .o_fb(o_fb), .o_sp(o_sp),
    .o_vector_table_base(o_vector_table_base), .o_pc(o_pc), .o_flags(o_flags));

  crf_eu_model eu (.i_clk(i_clk), .i_eu_rdata(o_eu_rdata), .o_we(we),
    .o_wsel(wsel), .o_wmode(wmode), .o_wdata(wdata), .o_rsel(rsel),
    .o_rmode(rmode), .o_alu(alu), .o_upd(upd), .o_pcl(pcl),
    .o_pc(pcn), .o_ack(ack), .o_swi(swi), .o_swi_num(swn));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // Debug flag and reserved bits always zero
  function automatic logic [31:0] cpu_flags(input logic b, input logic i,
                                      input logic u, input logic [2:0] p);
    return {17'h0, p, 4'h0, u, i, 1'b0, b, 4'h0};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; e is {pslverr, read data}
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    q.push_back(e);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20)
      check(32'h0, 32'h1);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  always @(posedge i_clk) begin
    if (psel && pen && o_pready === 1'b1) begin
      e_n = q.pop_front();
      check({31'h0, o_pslverr}, {31'h0, e_n[32]});
      if (!pwr)
        check(o_prdata, e_n[31:0]);
    end
  end

  initial begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {psel, pen, pwr, paddr, pwdata, irq, lvl} = '0;
    ce = 1'b1;
    i_nrst = 1'b0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdr(crf_pkg::OFS_FLG, 32'h0);
    rdr(crf_pkg::OFS_USP, 32'h0);
    for (int k = 0; k < 16; k++) begin
      v = rnd();
      wrr(8'(4 * k), v);
      bv[k] = v & ((k % 8 < 4) ? 32'h0000ffff : 32'h00ffffff);
    end
    for (int k = 0; k < 16; k++)
      rdr(8'(4 * k), bv[k]);
    // Even stack addresses keep interrupt entry short
    wrr(crf_pkg::OFS_USP, 32'h00abcd10);
    wrr(crf_pkg::OFS_ISP, 32'h00fe0020);
    wrr(crf_pkg::OFS_VECTOR_TABLE_BASE, 32'h00345600);
    for (int b = 0; b < 2; b++) begin
      wrr(crf_pkg::OFS_FLG, cpu_flags(b[0], 1'b0, b[0], 3'h0));
      @(negedge i_clk);
      check({8'h0, o_a0}, bv[8 * b + 4]);
      check({8'h0, o_a1}, bv[8 * b + 5]);
      check({8'h0, o_sb}, bv[8 * b + 6]);
      check({8'h0, o_fb}, bv[8 * b + 7]);
      check({8'h0, o_sp}, b ? 32'h00abcd10 : 32'h00fe0020);
      check({8'h0, o_vector_table_base}, 32'h00345600);
    end
    eu.wr(4'h0, crf_pkg::WM_LOW, 32'h000000a5);
    eu.wr(4'h0, crf_pkg::WM_HIGH, 32'h0000005a);
    eu.wr(4'h1, crf_pkg::WM_PAIR, 32'h1234cdef);
    rdr(crf_pkg::OFS_PAIR_LO, {bv[10][15:0], 16'h5aa5});
    rdr(crf_pkg::OFS_PAIR_HI, 32'h1234cdef);
    rdr(8'h00, bv[0]);
    eu.rd(4'h0, crf_pkg::WM_HIGH, v);
    check(v, 32'h0000005a);
    eu.rd(4'h1, crf_pkg::WM_PAIR, v);
    check(v, 32'h1234cdef);
    for (int k = 0; k < 16; k++) begin
      eu.ev(0, 24'(k));
      @(negedge i_clk);
      check({28'h0, o_flags[5], o_flags[3:2], o_flags[0]}, 32'(k));
    end
    for (int p = 0; p < 9; p++) begin
      wrr(crf_pkg::OFS_FLG, cpu_flags(1'b0, p < 8, 1'b0, 3'(p)));
      for (int l = 0; l < 8; l++) begin
        @(posedge i_clk);
        irq <= 1'b1;
        lvl <= 3'(l);
        @(negedge i_clk);
        check({31'h0, o_irq_accept}, {31'h0, p < 8 && l > p});
      end
    end
    irq <= 1'b0;
    // Hardware ack, software interrupt 31, then 32
    for (int k = 0; k < 3; k++) begin
      wrr(crf_pkg::OFS_FLG, cpu_flags(1'b0, 1'b1, 1'b1, 3'h5));
      eu.ev(k == 0 ? 1 : 2, k == 1 ? 24'h00001f : 24'h000020);
      @(negedge i_clk);
      check({30'h0, o_flags[6], o_flags[7]}, {30'h0, k != 0, k == 2});
    end
    rdr(crf_pkg::OFS_FLG, cpu_flags(1'b0, 1'b1, 1'b1, 3'h5));
    eu.ev(3, 24'habcde0);
    wrr(crf_pkg::OFS_PC, 32'h00111111);
    rdr(crf_pkg::OFS_PC, 32'h00abcde0);
    check({8'h0, o_pc}, 32'h00abcde0);
    // Clock enable low: the load strobe must not reach the counter
    ce <= 1'b0;
    eu.ev(3, 24'h000bad);
    @(posedge i_clk);
    ce <= 1'b1;
    @(negedge i_clk);
    check({8'h0, o_pc}, 32'h00abcde0);
    eu.wr(crf_pkg::SEL_SP, crf_pkg::WM_WORD, 32'h00123456);
    @(negedge i_clk);
    check({8'h0, o_sp}, 32'h00123456);
    eu.rd(crf_pkg::SEL_ISP, crf_pkg::WM_WORD, v);
    check(v, 32'h00fe0020);
    apb(1'b1, 8'h5c, rnd(), {1'b1, 32'h0});
    apb(1'b0, 8'h02, 32'h0, {1'b1, 32'h0});
    repeat (2) @(posedge i_clk);
    report_and_stop();
  end
endmodule

// ---- rtl/crf_bank.sv ----
// Two banks of eight banked registers with a registered read port
`timescale 1ns/1ps
module crf_bank (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  crf_bank_if.mem   bus
);
  typedef struct packed {
    logic [2*crf_pkg::NBANK-1:0][crf_pkg::AW-1:0] mem;
    logic [crf_pkg::AW-1:0]                       rd;
  } crf_bank_st_t;

  crf_bank_st_t st_reg;
  crf_bank_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (bus.we_a) begin
      st_next.mem[bus.wa_a] = (st_reg.mem[bus.wa_a] & ~bus.wm_a)
                            | (bus.wd_a & bus.wm_a);
    end
    if (bus.we_b) begin
      st_next.mem[bus.wa_b] = (st_reg.mem[bus.wa_b] & ~bus.wm_b)
                            | (bus.wd_b & bus.wm_b);
    end
    st_next.rd = st_reg.mem[bus.ra];
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // Active bank view, selected by the bank flag only
  for (genvar g = 0; g < crf_pkg::NBANK; g++) begin : g_act
    assign bus.act[g] = st_reg.mem[{bus.bank, 3'(g)}];
  end
  assign bus.rd = st_reg.rd;
endmodule

// ---- rtl/crf_bank_if.sv ----
// Link between the register file core and its banked store
`timescale 1ns/1ps
interface crf_bank_if;
  logic             we_a;
  logic             we_b;
  logic [3:0]       wa_a;
  logic [3:0]       wa_b;
  logic [23:0]      wd_a;
  logic [23:0]      wd_b;
  logic [23:0]      wm_a;
  logic [23:0]      wm_b;
  logic [3:0]       ra;
  logic [23:0]      rd;
  logic             bank;
  logic [7:0][23:0] act;
  modport host (output we_a, we_b, wa_a, wa_b, wd_a, wd_b, wm_a, wm_b,
                output ra, bank, input rd, act);
  modport mem  (input we_a, we_b, wa_a, wa_b, wd_a, wd_b, wm_a, wm_b,
                input ra, bank, output rd, act);
endinterface

// ---- rtl/crf_flags.sv ----
// Flag word: condition flags, selects, interrupt enable and level
`timescale 1ns/1ps
module crf_flags (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_we,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_alu_upd,
  input  wire logic        i_alu_c,
  input  wire logic        i_alu_z,
  input  wire logic        i_alu_s,
  input  wire logic        i_alu_o,
  input  wire logic        i_ack_hw,
  input  wire logic        i_swi,
  input  wire logic [5:0]  i_swi_num,
  output logic      [15:0] o_flags
);
  typedef struct packed {
    logic [15:0] cpu_flags;
  } crf_flag_st_t;

  crf_flag_st_t st_reg;
  crf_flag_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (i_we) begin
      st_next.cpu_flags = i_wdata & crf_pkg::FLG_WMASK;
    end
    if (i_alu_upd) begin
      st_next.cpu_flags[crf_pkg::FB_C] = i_alu_c;
      st_next.cpu_flags[crf_pkg::FB_Z] = i_alu_z;
      st_next.cpu_flags[crf_pkg::FB_S] = i_alu_s;
      st_next.cpu_flags[crf_pkg::FB_O] = i_alu_o;
    end
    if (i_ack_hw) begin
      st_next.cpu_flags[crf_pkg::FB_I] = 1'b0;
      st_next.cpu_flags[crf_pkg::FB_U] = 1'b0;
    end
    if (i_swi && (i_swi_num < crf_pkg::SWI_U_LIM)) begin
      st_next.cpu_flags[crf_pkg::FB_U] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg.cpu_flags <= crf_pkg::FLG_RST;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_flags = st_reg.cpu_flags;
endmodule

// ---- rtl/crf_pkg.sv ----
// Shared constants and types of the CPU register file
package crf_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  localparam int NBANK = 8;

  // APB byte offsets
  localparam logic [7:0] OFS_BANK0   = 8'h00;
  localparam logic [7:0] OFS_BANK1   = 8'h20;
  localparam logic [7:0] OFS_USP     = 8'h40;
  localparam logic [7:0] OFS_ISP     = 8'h44;
  localparam logic [7:0] OFS_VECTOR_TABLE_BASE    = 8'h48;
  localparam logic [7:0] OFS_PC      = 8'h4c;
  localparam logic [7:0] OFS_FLG     = 8'h50;
  localparam logic [7:0] OFS_PAIR_LO = 8'h54;
  localparam logic [7:0] OFS_PAIR_HI = 8'h58;

  // Flag word bit positions
  localparam int FB_C   = 0;
  localparam int FB_D   = 1;
  localparam int FB_Z   = 2;
  localparam int FB_S   = 3;
  localparam int FB_B   = 4;
  localparam int FB_O   = 5;
  localparam int FB_I   = 6;
  localparam int FB_U   = 7;
  localparam int FB_IPL = 12;
  localparam int IPL_W  = 3;

  localparam logic [15:0] FLG_RST   = 16'h0000;
  localparam logic [15:0] FLG_WMASK = 16'h70ff;
  localparam logic [23:0] PTR_RST   = 24'h000000;
  localparam logic [23:0] MASK_DATA = 24'h00ffff;
  localparam logic [23:0] MASK_ADDR = 24'hffffff;
  localparam logic [23:0] MASK_LOW  = 24'h0000ff;
  localparam logic [23:0] MASK_HIGH = 24'h00ff00;
  localparam logic [5:0]  SWI_U_LIM = 6'h20;

  // Execution unit register selects above the banked eight
  localparam logic [3:0] SEL_USP  = 4'h8;
  localparam logic [3:0] SEL_ISP  = 4'h9;
  localparam logic [3:0] SEL_VECTOR_TABLE_BASE = 4'ha;
  localparam logic [3:0] SEL_SP   = 4'hb;
  localparam logic [3:0] SEL_FLG  = 4'hc;

  typedef enum logic [1:0] {
    WM_WORD = 2'h0,
    WM_LOW  = 2'h1,
    WM_HIGH = 2'h2,
    WM_PAIR = 2'h3
  } crf_wmode_t;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_RD   = 2'b10
  } crf_apb_t;
endpackage

// ---- rtl/crf_top.sv ----
// CPU programmer-visible register file with APB access
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - two banks, each of four data, two address, static and frame base
// - data registers 16 bits; first two also written as byte halves
// - data zero with two, and one with three, form 32-bit pairs
// - both address registers 24 bits, usable as bases and operands
// - static and frame base 24 bits, each base of its mode
// - user and interrupt stack pointers, 24 bits, chosen by stack flag
// - vector-table base is a 24-bit register
// - program counter, 24 bits, holds the next instruction address
// - flag word is a 16-bit register of defined flag bits
// - carry flag records carry or borrow of each instruction
// - zero flag is one exactly when the result is zero
// - sign flag is one exactly when the result is negative
// - bank flag zero selects bank zero, one selects bank one
// - overflow flag is one exactly when the operation overflows
// - interrupt enable zero blocks maskable interrupts, one permits
// - acknowledging an interrupt clears interrupt enable
// - stack flag zero picks interrupt stack, one picks user stack
// - hardware ack or software interrupt 0 to 31 clears stack flag
// - 3-bit priority level; accept only requests above it
// - reserved flag bits written as zero; read value undefined
module crf_top (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_eu_we,
  input  wire logic [3:0]  i_eu_wsel,
  input  wire logic [1:0]  i_eu_wmode,
  input  wire logic [31:0] i_eu_wdata,
  input  wire logic [3:0]  i_eu_rsel,
  input  wire logic [1:0]  i_eu_rmode,
  output logic      [31:0] o_eu_rdata,
  input  wire logic        i_alu_upd,
  input  wire logic        i_alu_c,
  input  wire logic        i_alu_z,
  input  wire logic        i_alu_s,
  input  wire logic        i_alu_o,
  input  wire logic        i_pc_load,
  input  wire logic [23:0] i_pc_next,
  input  wire logic        i_irq_req,
  input  wire logic [2:0]  i_irq_lvl,
  output logic             o_irq_accept,
  input  wire logic        i_ack_hw,
  input  wire logic        i_swi,
  input  wire logic [5:0]  i_swi_num,
  output logic      [23:0] o_a0,
  output logic      [23:0] o_a1,
  output logic      [23:0] o_sb,
  output logic      [23:0] o_fb,
  output logic      [23:0] o_sp,
  output logic      [23:0] o_vector_table_base,
  output logic      [23:0] o_pc,
  output logic      [15:0] o_flags
);
  typedef struct packed {
    logic [23:0]       user_stack_pointer;
    logic [23:0]       interrupt_stack_pointer;
    logic [23:0]       vector_table_base;
    logic [23:0]       pc;
    logic [31:0]       eu_rd;
    logic [31:0]       prdata;
    crf_pkg::crf_apb_t ap;
  } crf_top_st_t;

  crf_top_st_t st_reg;
  crf_top_st_t st_next;
  crf_bank_if  bif ();

  logic        fl_we;
  logic [15:0] fl_wd;
  logic        apb_acc;
  logic        apb_wr;
  logic        apb_rd;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [15:0] cpu_flags;
  logic        bsel;
  logic        usel;

  crf_bank u_bank (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .bus    (bif.mem)
  );

  crf_flags u_flags (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_we      (fl_we),
    .i_wdata   (fl_wd),
    .i_alu_upd (i_alu_upd),
    .i_alu_c   (i_alu_c),
    .i_alu_z   (i_alu_z),
    .i_alu_s   (i_alu_s),
    .i_alu_o   (i_alu_o),
    .i_ack_hw  (i_ack_hw),
    .i_swi     (i_swi),
    .i_swi_num (i_swi_num),
    .o_flags   (cpu_flags)
  );

  assign bsel = cpu_flags[crf_pkg::FB_B];
  assign usel = cpu_flags[crf_pkg::FB_U];

  // Byte, word or register-pair view for the execution unit
  function automatic logic [31:0] eu_view(input logic [3:0] sel,
                                          input logic [1:0] md,
                                          input logic [23:0] v,
                                          input logic [7:0][23:0] act);
    logic [31:0] r;
    r = {8'h00, v};
    if (md == crf_pkg::WM_LOW && sel < 4'h2) begin
      r = {24'h000000, v[7:0]};
    end else if (md == crf_pkg::WM_HIGH && sel < 4'h2) begin
      r = {24'h000000, v[15:8]};
    end else if (md == crf_pkg::WM_PAIR && sel < 4'h2) begin
      r = {act[{1'b1, sel[0]}][15:0], act[{1'b0, sel[0]}][15:0]};
    end
    return r;
  endfunction

  logic [23:0] eu_src;
  always_comb begin
    unique case (i_eu_rsel)
      crf_pkg::SEL_USP:  eu_src = st_reg.user_stack_pointer;
      crf_pkg::SEL_ISP:  eu_src = st_reg.interrupt_stack_pointer;
      crf_pkg::SEL_VECTOR_TABLE_BASE: eu_src = st_reg.vector_table_base;
      crf_pkg::SEL_SP:   eu_src = o_sp;
      crf_pkg::SEL_FLG:  eu_src = {8'h00, cpu_flags};
      default:           eu_src = i_eu_rsel[3] ? 24'h000000
                                               : bif.act[i_eu_rsel[2:0]];
    endcase
  end

  assign apb_acc = i_psel & i_penable;
  assign apb_wr  = apb_acc & i_pwrite & ~i_eu_we;
  assign apb_rd  = apb_acc & ~i_pwrite & (st_reg.ap == crf_pkg::AP_IDLE);
  assign mapped  = (i_paddr[1:0] == 2'h0) &&
                   (i_paddr <= crf_pkg::OFS_PAIR_HI);

  // APB read mux, sampled in the first access cycle
  always_comb begin
    unique case (i_paddr)
      crf_pkg::OFS_USP:     rd_mux = {8'h00, st_reg.user_stack_pointer};
      crf_pkg::OFS_ISP:     rd_mux = {8'h00, st_reg.interrupt_stack_pointer};
      crf_pkg::OFS_VECTOR_TABLE_BASE:    rd_mux = {8'h00, st_reg.vector_table_base};
      crf_pkg::OFS_PC:      rd_mux = {8'h00, st_reg.pc};
      crf_pkg::OFS_FLG:     rd_mux = {16'h0000, cpu_flags};
      crf_pkg::OFS_PAIR_LO: rd_mux = {bif.act[2][15:0], bif.act[0][15:0]};
      crf_pkg::OFS_PAIR_HI: rd_mux = {bif.act[3][15:0], bif.act[1][15:0]};
      default:              rd_mux = (i_paddr < crf_pkg::OFS_USP && mapped)
                                     ? {8'h00, bif.rd} : 32'h00000000;
    endcase
  end

  always_comb begin
    st_next   = st_reg;
    bif.we_a  = 1'b0;
    bif.we_b  = 1'b0;
    bif.wa_a  = 4'h0;
    bif.wa_b  = 4'h0;
    bif.wd_a  = 24'h000000;
    bif.wd_b  = 24'h000000;
    bif.wm_a  = crf_pkg::MASK_ADDR;
    bif.wm_b  = crf_pkg::MASK_DATA;
    bif.ra    = i_paddr[5:2];
    bif.bank  = bsel;
    fl_we     = 1'b0;
    fl_wd     = 16'h0000;
    if (i_eu_we) begin
      if (!i_eu_wsel[3]) begin
        bif.we_a = 1'b1;
        bif.wa_a = {bsel, i_eu_wsel[2:0]};
        bif.wd_a = i_eu_wdata[23:0];
        if (!i_eu_wsel[2]) begin
          bif.wm_a = crf_pkg::MASK_DATA;
        end
        if (i_eu_wsel < 4'h2) begin
          unique case (i_eu_wmode)
            crf_pkg::WM_LOW: begin
              bif.wm_a = crf_pkg::MASK_LOW;
            end
            crf_pkg::WM_HIGH: begin
              bif.wm_a = crf_pkg::MASK_HIGH;
              bif.wd_a = {8'h00, i_eu_wdata[7:0], 8'h00};
            end
            crf_pkg::WM_PAIR: begin
              bif.we_b = 1'b1;
              bif.wa_b = {bsel, 1'b0, 1'b1, i_eu_wsel[0]};
              bif.wd_b = {8'h00, i_eu_wdata[31:16]};
            end
            default: ;
          endcase
        end
      end else begin
        unique case (i_eu_wsel)
          crf_pkg::SEL_USP:  st_next.user_stack_pointer = i_eu_wdata[23:0];
          crf_pkg::SEL_ISP:  st_next.interrupt_stack_pointer = i_eu_wdata[23:0];
          crf_pkg::SEL_VECTOR_TABLE_BASE: st_next.vector_table_base = i_eu_wdata[23:0];
          crf_pkg::SEL_SP: begin
            if (usel) begin
              st_next.user_stack_pointer = i_eu_wdata[23:0];
            end else begin
              st_next.interrupt_stack_pointer = i_eu_wdata[23:0];
            end
          end
          crf_pkg::SEL_FLG: begin
            fl_we = 1'b1;
            fl_wd = i_eu_wdata[15:0];
          end
          default: ;
        endcase
      end
    end else if (apb_wr && mapped) begin
      if (i_paddr < crf_pkg::OFS_USP) begin
        bif.we_a = 1'b1;
        bif.wa_a = i_paddr[5:2];
        bif.wd_a = i_pwdata[23:0];
        if (!i_paddr[4]) begin
          bif.wm_a = crf_pkg::MASK_DATA;
        end
      end else begin
        unique case (i_paddr)
          crf_pkg::OFS_USP:  st_next.user_stack_pointer = i_pwdata[23:0];
          crf_pkg::OFS_ISP:  st_next.interrupt_stack_pointer = i_pwdata[23:0];
          crf_pkg::OFS_VECTOR_TABLE_BASE: st_next.vector_table_base = i_pwdata[23:0];
          crf_pkg::OFS_FLG: begin
            fl_we = 1'b1;
            fl_wd = i_pwdata[15:0];
          end
          crf_pkg::OFS_PAIR_LO, crf_pkg::OFS_PAIR_HI: begin
            bif.we_a = 1'b1;
            bif.we_b = 1'b1;
            bif.wa_a = {bsel, 2'b00, i_paddr[3]};
            bif.wa_b = {bsel, 2'b01, i_paddr[3]};
            bif.wm_a = crf_pkg::MASK_DATA;
            bif.wd_a = {8'h00, i_pwdata[15:0]};
            bif.wd_b = {8'h00, i_pwdata[31:16]};
          end
          default: ;
        endcase
      end
    end
    if (i_pc_load) begin
      st_next.pc = i_pc_next;
    end
    st_next.eu_rd = eu_view(i_eu_rsel, i_eu_rmode, eu_src, bif.act);
    unique case (st_reg.ap)
      crf_pkg::AP_IDLE: begin
        if (apb_rd) begin
          st_next.prdata = rd_mux;
          st_next.ap     = crf_pkg::AP_RD;
        end
      end
      crf_pkg::AP_RD: st_next.ap = crf_pkg::AP_IDLE;
      default:        st_next.ap = crf_pkg::AP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg.user_stack_pointer    <= crf_pkg::PTR_RST;
      st_reg.interrupt_stack_pointer    <= crf_pkg::PTR_RST;
      st_reg.vector_table_base   <= crf_pkg::PTR_RST;
      st_reg.pc     <= crf_pkg::PTR_RST;
      st_reg.eu_rd  <= 32'h00000000;
      st_reg.prdata <= 32'h00000000;
      st_reg.ap     <= crf_pkg::AP_IDLE;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // Writes wait while the execution unit writes; reads take two cycles
  assign o_pready  = apb_acc & (i_pwrite ? ~i_eu_we
                                         : (st_reg.ap == crf_pkg::AP_RD));
  assign o_pslverr = o_pready & ~mapped;
  assign o_prdata  = st_reg.prdata;
  assign o_eu_rdata = st_reg.eu_rd;

  assign o_a0   = bif.act[4];
  assign o_a1   = bif.act[5];
  assign o_sb   = bif.act[6];
  assign o_fb   = bif.act[7];
  assign o_sp   = usel ? st_reg.user_stack_pointer : st_reg.interrupt_stack_pointer;
  assign o_vector_table_base = st_reg.vector_table_base;
  assign o_pc   = st_reg.pc;
  assign o_flags = cpu_flags;

  assign o_irq_accept = i_irq_req & cpu_flags[crf_pkg::FB_I]
    & (i_irq_lvl > cpu_flags[crf_pkg::FB_IPL +: crf_pkg::IPL_W]);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  ack_clr_i_a: assert property (
    i_ce && i_ack_hw |=> !cpu_flags[crf_pkg::FB_I] && !o_irq_accept)
    else $error("interrupt enable not cleared by ack");
  ack_clr_u_a: assert property (
    i_ce && (i_ack_hw || (i_swi && i_swi_num < 6'h20)) |=> !usel)
    else $error("stack select not cleared");
  alu_flags_a: assert property (
    i_ce && i_alu_upd && !i_eu_we |=> cpu_flags[crf_pkg::FB_Z] == $past(i_alu_z)
      && cpu_flags[crf_pkg::FB_C] == $past(i_alu_c))
    else $error("zero or carry flag wrong");
  sign_ovf_a: assert property (
    i_ce && i_alu_upd |=> cpu_flags[crf_pkg::FB_S] == $past(i_alu_s)
      && cpu_flags[crf_pkg::FB_O] == $past(i_alu_o))
    else $error("sign or overflow flag wrong");
  reserved_zero_a: assert property (
    (cpu_flags & ~crf_pkg::FLG_WMASK) == 16'h0000)
    else $error("reserved flag bit set");
  irq_gate_a: assert property (
    o_irq_accept |-> cpu_flags[crf_pkg::FB_I] &&
      i_irq_lvl > cpu_flags[crf_pkg::FB_IPL +: crf_pkg::IPL_W])
    else $error("interrupt accepted at or below level");
  sp_write_a: assert property (
    i_ce && i_eu_we && i_eu_wsel == crf_pkg::SEL_SP && !i_ack_hw && !i_swi
      |=> o_sp == $past(i_eu_wdata[23:0]))
    else $error("active stack pointer write lost");
  pc_load_a: assert property (
    i_ce && i_pc_load |=> o_pc == $past(i_pc_next))
    else $error("program counter not loaded");
  bank_swap_a: assert property (
    $changed(bsel) && $past(apb_wr) && $past(i_paddr) == crf_pkg::OFS_FLG
      |-> $stable(st_reg.user_stack_pointer) && $stable(st_reg.interrupt_stack_pointer) && $stable(o_vector_table_base))
    else $error("shared register changed on bank swap");
  pair_read_a: assert property (
    i_ce && i_eu_rsel < 4'h2 && i_eu_rmode == crf_pkg::WM_PAIR
      && !i_eu_we && !apb_wr && $stable(bsel)
      |=> o_eu_rdata == ($past(i_eu_rsel[0])
        ? {bif.act[3][15:0], bif.act[1][15:0]}
        : {bif.act[2][15:0], bif.act[0][15:0]}))
    else $error("pair read wrong");
  apb_rd_wait_a: assert property (
    i_ce && apb_rd |-> !o_pready ##1 o_pready)
    else $error("read answer not in second access cycle");

  irq_c: cover property (o_irq_accept ##1 i_ack_hw);
  bank_c: cover property ($rose(bsel));
  apb_rd_c: cover property (o_pready && !i_pwrite);
  pair_wr_c: cover property (
    i_eu_we && i_eu_wmode == crf_pkg::WM_PAIR && i_eu_wsel < 4'h2);
endmodule
